// File: hw/cldec_pkg.sv
// Purpose: Shared constants, types and decode functions of the branch and EEPROM slice
// Assumes: Instruction fetch supplies a fully decoded instruction word
// Notes: Lengths are in bytes, durations in clock cycles
package cldec_pkg;

  localparam int unsigned ACC_W = 24;
  localparam int unsigned PC_W = 10;
  localparam int unsigned ACC_NUM = 4;
  localparam int unsigned CNT_W = 3;

  // EEPROM layout: 16 configuration words of 3 bytes below user code
  localparam logic [PC_W-1:0] CFG_WORD_BYTES = 10'h003;
  localparam logic [PC_W-1:0] USER_CODE_BASE = 10'h030;
  localparam int unsigned REL_OFS_W = 8;

  // Instruction lengths in bytes
  localparam logic [PC_W-1:0] LEN_1 = 10'h001;
  localparam logic [PC_W-1:0] LEN_2 = 10'h002;
  localparam logic [PC_W-1:0] LEN_3 = 10'h003;
  localparam logic [PC_W-1:0] LEN_5 = 10'h005;

  // Instruction durations in cycles
  localparam logic [CNT_W-1:0] CYC_XNOR_ACC = 3'h3;
  localparam logic [CNT_W-1:0] CYC_XNOR_IMM = 3'h6;
  localparam logic [CNT_W-1:0] CYC_CFG_WR = 3'h3;
  localparam logic [CNT_W-1:0] CYC_EE_RD = 3'h6;
  localparam logic [CNT_W-1:0] CYC_FLAG = 3'h1;
  localparam logic [CNT_W-1:0] CYC_JMP_REL = 3'h3;
  localparam logic [CNT_W-1:0] CYC_JMP_ABS = 3'h4;
  localparam logic [CNT_W-1:0] CYC_ONE = 3'h1;

  typedef enum logic [3:0] {
    OP_XNOR = 4'h0,
    OP_CFG_WR = 4'h1,
    OP_EE_RD = 4'h2,
    OP_FLAG_TEST = 4'h3,
    OP_JUMP = 4'h4,
    OP_BRANCH_BIT_CLEAR = 4'h5,
    OP_BRANCH_BIT_SET = 4'h6,
    OP_BRANCH_CARRY_CLEAR = 4'h7,
    OP_BRANCH_CARRY_SET = 4'h8,
    OP_BRANCH_RESULT_ZERO = 4'h9,
    OP_BRANCH_RESULT_NONZERO = 4'hA,
    OP_BRANCH_RESULT_NEGATIVE = 4'hB,
    OP_BRANCH_RESULT_POSITIVE = 4'hC
  } cldec_op_e;

  typedef struct packed {
    cldec_op_e op;
    logic [1:0] dst_sel;
    logic [1:0] src_sel;
    logic use_imm;
    logic [ACC_W-1:0] imm;
    logic [4:0] bit_sel;
    logic abs_form;
    logic [PC_W-1:0] target;
    logic [3:0] cfg_idx;
  } cldec_instr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cldec_state_e;

  function automatic logic [PC_W-1:0] instr_len(input cldec_instr_s ins);
    logic [PC_W-1:0] len;
    len = LEN_1;
    unique case (ins.op)
      OP_XNOR: len = ins.use_imm ? LEN_5 : LEN_2;
      OP_CFG_WR, OP_BRANCH_BIT_CLEAR, OP_BRANCH_BIT_SET: len = LEN_3;
      OP_EE_RD, OP_FLAG_TEST: len = LEN_1;
      default: len = ins.abs_form ? LEN_3 : LEN_2;
    endcase
    return len;
  endfunction

  function automatic logic [CNT_W-1:0] instr_cycles(input cldec_instr_s ins);
    logic [CNT_W-1:0] cyc;
    cyc = CYC_ONE;
    unique case (ins.op)
      OP_XNOR: cyc = ins.use_imm ? CYC_XNOR_IMM : CYC_XNOR_ACC;
      OP_CFG_WR: cyc = CYC_CFG_WR;
      OP_EE_RD: cyc = CYC_EE_RD;
      OP_FLAG_TEST: cyc = CYC_FLAG;
      OP_BRANCH_BIT_CLEAR, OP_BRANCH_BIT_SET: cyc = CYC_JMP_ABS;
      default: cyc = ins.abs_form ? CYC_JMP_ABS : CYC_JMP_REL;
    endcase
    return cyc;
  endfunction

endpackage

// File: hw/cldec_eval.sv
// Purpose: Combinational XNOR result and branch condition of the latched instruction
// Assumes: Operands and flags are stable while the instruction executes
// Notes: Pure logic, no state
`timescale 1ns/100ps
module cldec_eval #(
  parameter int unsigned W = cldec_pkg::ACC_W
) (
  // Instruction and operands
  input wire cldec_pkg::cldec_instr_s instr_i,
  input wire logic [W-1:0] dst_val_i,
  input wire logic [W-1:0] src_val_i,
  // Flags
  input wire logic sign_i,
  input wire logic nonzero_i,
  input wire logic carry_i,
  // Results
  output logic [W-1:0] xnor_o,
  output logic taken_o
);

  logic [W-1:0] operand;

  always_comb begin
    operand = instr_i.use_imm ? instr_i.imm[W-1:0] : src_val_i; // see [RQ1]
    xnor_o = ~(dst_val_i ^ operand); // see [RQ2]
    taken_o = 1'b0;
    unique case (instr_i.op)
      cldec_pkg::OP_JUMP: taken_o = 1'b1; // see [RQ9]
      cldec_pkg::OP_BRANCH_BIT_CLEAR: taken_o = ~dst_val_i[instr_i.bit_sel]; // see [RQ10]
      cldec_pkg::OP_BRANCH_BIT_SET: taken_o = dst_val_i[instr_i.bit_sel]; // see [RQ11]
      cldec_pkg::OP_BRANCH_CARRY_CLEAR: taken_o = ~carry_i; // see [RQ12]
      cldec_pkg::OP_BRANCH_CARRY_SET: taken_o = carry_i; // see [RQ12]
      cldec_pkg::OP_BRANCH_RESULT_ZERO: taken_o = ~nonzero_i; // see [RQ13]
      cldec_pkg::OP_BRANCH_RESULT_NONZERO: taken_o = nonzero_i; // see [RQ14]
      cldec_pkg::OP_BRANCH_RESULT_NEGATIVE: taken_o = sign_i; // see [RQ15]
      cldec_pkg::OP_BRANCH_RESULT_POSITIVE: taken_o = ~sign_i; // see [RQ16]
      default: taken_o = 1'b0;
    endcase
  end

endmodule

// File: hw/cldec_core.sv
// Purpose: Execute slice for XNOR, config write, EEPROM read, flag test and jumps
// Assumes: Same-clock decoded instructions; EEPROM data valid at the final read cycle
// Notes: One instruction at a time; a new one may be taken on the completing edge
// Function
// [RQ1] Four 24-bit working registers, each usable as first or second operand.
// [RQ2] XNOR replaces first register with bitwise equivalence; sign and nonzero updated.
// [RQ3] XNOR: 2 bytes 3 cycles register form, 5 bytes 6 cycles immediate.
// [RQ4] Config write stores 24-bit immediate to EEPROM config word, flags untouched.
// [RQ5] Config occupies bytes 0 to 47 as sixteen words; code starts at 48.
// [RQ6] EEPROM read loads register from pointer address, sets flags, 1 byte 6 cycles.
// [RQ7] EEPROM read holds one program-counter stack entry until it completes.
// [RQ8] Flag test sets sign and nonzero from register, unchanged, 1 byte 1 cycle.
// [RQ9] Jump loads target; relative 2 bytes 3 cycles, absolute 3 bytes 4 cycles.
// [RQ10] Bit-clear branch taken when chosen bit 0..23 is zero; 3 bytes 4 cycles.
// [RQ11] Bit-set branch taken when chosen bit is one; same format.
// [RQ12] Carry branches taken on carry clear or set; relative and absolute forms.
// [RQ13] Zero branch taken when nonzero flag is clear.
// [RQ14] Nonzero branch taken when nonzero flag is set.
// [RQ15] Negative branch taken when sign flag is set.
// [RQ16] Positive branch taken when sign flag is clear.
// [RQ17] Untaken branch continues at the instruction after the jump.
`timescale 1ns/100ps
module cldec_core #(
  parameter int unsigned W = cldec_pkg::ACC_W,
  parameter int unsigned PW = cldec_pkg::PC_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Instruction issue
  input wire logic issue_valid_i,
  input wire cldec_pkg::cldec_instr_s issue_instr_i,
  output logic ready_o,
  output logic done_o,
  output logic branch_taken_o,
  // Processor state
  input wire logic carry_i,
  input wire logic [PW-1:0] ram_addr_i,
  output logic [cldec_pkg::ACC_NUM-1:0][W-1:0] working_register_o,
  output logic sign_o,
  output logic nonzero_o,
  output logic [PW-1:0] pc_o,
  output logic stack_hold_o,
  // EEPROM port
  output logic ee_rd_o,
  output logic ee_wr_o,
  output logic [PW-1:0] ee_addr_o,
  output logic [W-1:0] ee_wdata_o,
  input wire logic [W-1:0] ee_rdata_i
);

  cldec_pkg::cldec_state_e state_r, state_nxt;
  cldec_pkg::cldec_instr_s instr_r, instr_nxt;
  logic [cldec_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [cldec_pkg::ACC_NUM-1:0][W-1:0] acc_r, acc_nxt;
  logic sign_r, sign_nxt, nz_r, nz_nxt;
  logic [PW-1:0] pc_r, pc_nxt;
  logic ready_r, ready_nxt, done_r, done_nxt, taken_r, taken_nxt;
  logic hold_r, hold_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic [PW-1:0] addr_r, addr_nxt;
  logic [W-1:0] wdata_r, wdata_nxt;
  logic [W-1:0] xnor_res;
  logic cond_taken;
  logic accept, finish;
  logic [PW-1:0] seq_pc, rel_pc;

  // Sign is the top bit, nonzero is any bit set
  function automatic logic [1:0] flags_of(input logic [W-1:0] v);
    return {v[W-1], |v};
  endfunction

  cldec_eval #(
    .W(W)
  ) u_eval (
    .instr_i(instr_r),
    .dst_val_i(acc_r[instr_r.dst_sel]),
    .src_val_i(acc_r[instr_r.src_sel]),
    .sign_i(sign_r),
    .nonzero_i(nz_r),
    .carry_i(carry_i),
    .xnor_o(xnor_res),
    .taken_o(cond_taken)
  );

  assign accept = issue_valid_i && ready_r;
  assign finish = (state_r == cldec_pkg::ST_EXEC) && (cnt_r == cldec_pkg::CYC_ONE);
  assign seq_pc = pc_r + cldec_pkg::instr_len(instr_r);
  // Relative offset is a signed byte from the following instruction
  assign rel_pc = seq_pc + {{(PW-cldec_pkg::REL_OFS_W){instr_r.target[cldec_pkg::REL_OFS_W-1]}},
                            instr_r.target[cldec_pkg::REL_OFS_W-1:0]};

  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    sign_nxt = sign_r;
    nz_nxt = nz_r;
    pc_nxt = pc_r;
    done_nxt = 1'b0;
    taken_nxt = taken_r;
    hold_nxt = hold_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    if (state_r == cldec_pkg::ST_EXEC) begin
      cnt_nxt = cnt_r - cldec_pkg::CYC_ONE;
    end
    if (finish) begin
      done_nxt = 1'b1;
      taken_nxt = 1'b0;
      state_nxt = cldec_pkg::ST_IDLE;
      pc_nxt = seq_pc; // see [RQ17]
      unique case (instr_r.op)
        cldec_pkg::OP_XNOR: begin
          acc_nxt[instr_r.dst_sel] = xnor_res; // see [RQ2]
          {sign_nxt, nz_nxt} = flags_of(xnor_res);
        end
        cldec_pkg::OP_EE_RD: begin
          acc_nxt[instr_r.dst_sel] = ee_rdata_i; // see [RQ6]
          {sign_nxt, nz_nxt} = flags_of(ee_rdata_i);
          hold_nxt = 1'b0; // see [RQ7]
        end
        cldec_pkg::OP_FLAG_TEST: begin
          {sign_nxt, nz_nxt} = flags_of(acc_r[instr_r.dst_sel]); // see [RQ8]
        end
        cldec_pkg::OP_CFG_WR: begin
          pc_nxt = seq_pc; // see [RQ4]
        end
        default: begin
          if (cond_taken) begin
            taken_nxt = 1'b1;
            pc_nxt = (instr_r.abs_form || instr_r.op == cldec_pkg::OP_BRANCH_BIT_CLEAR ||
                      instr_r.op == cldec_pkg::OP_BRANCH_BIT_SET) ? instr_r.target :
                     rel_pc; // see [RQ9]
          end
        end
      endcase
    end
    if (accept) begin
      state_nxt = cldec_pkg::ST_EXEC;
      instr_nxt = issue_instr_i;
      cnt_nxt = cldec_pkg::instr_cycles(issue_instr_i); // see [RQ3]
      if (issue_instr_i.op == cldec_pkg::OP_EE_RD) begin
        rd_nxt = 1'b1;
        hold_nxt = 1'b1; // see [RQ7]
        addr_nxt = ram_addr_i; // see [RQ6]
      end
      if (issue_instr_i.op == cldec_pkg::OP_CFG_WR) begin
        wr_nxt = 1'b1;
        // Index is 4 bits, so the address never reaches user code
        addr_nxt = PW'(issue_instr_i.cfg_idx) * cldec_pkg::CFG_WORD_BYTES; // see [RQ5]
        wdata_nxt = issue_instr_i.imm[W-1:0]; // see [RQ4]
      end
    end
    ready_nxt = (state_nxt == cldec_pkg::ST_IDLE) || (cnt_nxt == cldec_pkg::CYC_ONE);
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= cldec_pkg::ST_IDLE;
      instr_r <= '0;
      cnt_r <= '0;
      acc_r <= '0;
      sign_r <= 1'b0;
      nz_r <= 1'b0;
      pc_r <= cldec_pkg::USER_CODE_BASE;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      taken_r <= 1'b0;
      hold_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      sign_r <= sign_nxt;
      nz_r <= nz_nxt;
      pc_r <= pc_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      taken_r <= taken_nxt;
      hold_r <= hold_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign ready_o = ready_r;
  assign done_o = done_r;
  assign branch_taken_o = taken_r;
  assign working_register_o = acc_r;
  assign sign_o = sign_r;
  assign nonzero_o = nz_r;
  assign pc_o = pc_r;
  assign stack_hold_o = hold_r;
  assign ee_rd_o = rd_r;
  assign ee_wr_o = wr_r;
  assign ee_addr_o = addr_r;
  assign ee_wdata_o = wdata_r;

  // Done trails the completing edge by a cycle; the cycle after accept may hold an older done
  a_flag_timing: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ8]
    accept && issue_instr_i.op == cldec_pkg::OP_FLAG_TEST |=> ##1 done_r)
    else $error("flag test did not finish in one cycle");

  a_xnor_acc_time: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ3]
    accept && issue_instr_i.op == cldec_pkg::OP_XNOR && !issue_instr_i.use_imm
    |=> ##1 !done_r [*2] ##1 done_r)
    else $error("register xnor not three cycles");

  a_xnor_imm_time: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ3]
    accept && issue_instr_i.op == cldec_pkg::OP_XNOR && issue_instr_i.use_imm
    |=> ##1 !done_r [*5] ##1 done_r)
    else $error("immediate xnor not six cycles");

  // A back-to-back accept replaces instr_r on the completing edge, so look one cycle back
  a_xnor_value: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ2]
    done_r && $past(instr_r.op) == cldec_pkg::OP_XNOR |->
    acc_r[$past(instr_r.dst_sel)] == ~($past(acc_r[instr_r.dst_sel]) ^
      ($past(instr_r.use_imm) ? $past(instr_r.imm) : $past(acc_r[instr_r.src_sel]))))
    else $error("xnor result wrong");

  a_stack_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ7]
    accept && issue_instr_i.op == cldec_pkg::OP_EE_RD
    |=> stack_hold_o [*6] ##1 (!stack_hold_o || ee_rd_o))
    else $error("stack entry not held for the read");

  a_read_load: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ6]
    done_r && $past(instr_r.op) == cldec_pkg::OP_EE_RD |->
    acc_r[$past(instr_r.dst_sel)] == $past(ee_rdata_i) && nz_r == (|$past(ee_rdata_i)))
    else $error("eeprom read not loaded");

  a_cfg_addr: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ5]
    ee_wr_o |-> ee_addr_o < cldec_pkg::USER_CODE_BASE &&
    ee_addr_o == PW'(instr_r.cfg_idx) * cldec_pkg::CFG_WORD_BYTES)
    else $error("config write outside config area");

  a_cfg_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ4]
    done_r && $past(instr_r.op) == cldec_pkg::OP_CFG_WR |->
    $stable(sign_r) && $stable(nz_r))
    else $error("config write changed flags");

  a_fall_through: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ17]
    done_r && !taken_r |-> pc_r == $past(pc_r) + cldec_pkg::instr_len($past(instr_r)))
    else $error("untaken path did not advance pc");

  a_bit_branch: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ10]
    done_r && $past(instr_r.op) == cldec_pkg::OP_BRANCH_BIT_CLEAR |->
    taken_r == !$past(acc_r[instr_r.dst_sel][instr_r.bit_sel]) &&
    (!taken_r || pc_r == $past(instr_r.target)))
    else $error("bit clear branch wrong");

  a_zero_branch: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ13]
    done_r && $past(instr_r.op) == cldec_pkg::OP_BRANCH_RESULT_ZERO |->
    taken_r == !$past(nz_r))
    else $error("zero branch wrong");

  a_jump_abs_time: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see [RQ9]
    accept && issue_instr_i.op == cldec_pkg::OP_JUMP && issue_instr_i.abs_form
    |-> ##5 done_r && taken_r && pc_r == $past(issue_instr_i.target, 5))
    else $error("absolute jump wrong");

endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the branch and EEPROM execute slice
// Assumes: Inputs driven by non-blocking assignment at the rising edge, outputs read at falling
// Notes: Working register values are mirrored here so register expectations never come from the design
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_top;
  logic ref_clk_i;
  logic reset_i;
  logic issue_valid_i;
  cldec_pkg::cldec_instr_s issue_instr_i;
  logic carry_i;
  logic [cldec_pkg::PC_W-1:0] ram_addr_i;
  logic [cldec_pkg::ACC_W-1:0] ee_rdata_i;
  logic ready_o, done_o, branch_taken_o, sign_o, nonzero_o, stack_hold_o, ee_rd_o, ee_wr_o;
  logic [cldec_pkg::ACC_NUM-1:0][cldec_pkg::ACC_W-1:0] working_register_o;
  logic [cldec_pkg::PC_W-1:0] pc_o, ee_addr_o, exp_pc;
  logic [cldec_pkg::ACC_W-1:0] ee_wdata_o;
  logic [23:0] acc [4];
  logic rd1, wr1, hold_ok;
  int n_errors, compares, cyc;

  cldec_core DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i),
    .ready_o(ready_o), .done_o(done_o), .branch_taken_o(branch_taken_o),
    .carry_i(carry_i), .ram_addr_i(ram_addr_i), .working_register_o(working_register_o),
    .sign_o(sign_o), .nonzero_o(nonzero_o), .pc_o(pc_o), .stack_hold_o(stack_hold_o),
    .ee_rd_o(ee_rd_o), .ee_wr_o(ee_wr_o), .ee_addr_o(ee_addr_o),
    .ee_wdata_o(ee_wdata_o), .ee_rdata_i(ee_rdata_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic cldec_pkg::cldec_instr_s mk(input cldec_pkg::cldec_op_e op, input int d,
      input int s, input logic ui, input logic [23:0] im, input logic [4:0] bs,
      input logic ab, input logic [9:0] tg, input logic [3:0] ix);
    cldec_pkg::cldec_instr_s i;
    i = '{op: op, dst_sel: 2'(d), src_sel: 2'(s), use_imm: ui, imm: im, bit_sel: bs,
          abs_form: ab, target: tg, cfg_idx: ix};
    return i;
  endfunction

  // Offer, wait for accept, then count cycles to completion
  task automatic run(input cldec_pkg::cldec_instr_s ins);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b1;
    issue_instr_i <= ins;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (ready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      results();
    end
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b0;
    cyc = 0;
    hold_ok = 1'b1;
    do begin
      @(negedge ref_clk_i);
      cyc++;
      if (cyc == 1) begin
        rd1 = ee_rd_o;
        wr1 = ee_wr_o;
      end
      // Stack entry is owned only by an EEPROM read in flight
      if (done_o !== 1'b1 && stack_hold_o !== (ins.op == cldec_pkg::OP_EE_RD))
        hold_ok = 1'b0;
    end while (done_o !== 1'b1 && cyc < 20);
    if (cyc >= 20) begin
      n_errors++;
      results();
    end
    // Done shows one cycle after the completing edge
    cyc = cyc - 1;
  endtask

  task automatic t_reset();
    repeat (2) @(posedge ref_clk_i);
    `CHK(pc_o, 10'h030)
    `CHK(working_register_o, 96'h0)
    reset_i <= 1'b0;
    exp_pc = 10'h030;
  endtask

  task automatic t_ee_read(input int d, input logic [23:0] v, input logic [9:0] ptr);
    @(posedge ref_clk_i);
    ram_addr_i <= ptr;
    ee_rdata_i <= v;
    run(mk(cldec_pkg::OP_EE_RD, d, 0, 1'b0, 24'h0, 5'h00, 1'b0, 10'h000, 4'h0));
    `CHK(cyc, 6)
    `CHK(rd1, 1'b1)
    `CHK(ee_addr_o, ptr)
    `CHK(hold_ok, 1'b1)
    `CHK(working_register_o[d], v)
    `CHK(sign_o, v[23])
    `CHK(nonzero_o, 1'(v != 24'h0))
    exp_pc = exp_pc + 10'h001;
    `CHK(pc_o, exp_pc)
    acc[d] = v;
    @(negedge ref_clk_i);
    `CHK(stack_hold_o, 1'b0)
  endtask

  task automatic t_flag(input int d);
    run(mk(cldec_pkg::OP_FLAG_TEST, d, 0, 1'b0, 24'h0, 5'h00, 1'b0, 10'h000, 4'h0));
    `CHK(cyc, 1)
    `CHK(sign_o, acc[d][23])
    `CHK(nonzero_o, 1'(acc[d] != 24'h0))
    `CHK(working_register_o[d], acc[d])
    exp_pc = exp_pc + 10'h001;
    `CHK(pc_o, exp_pc)
  endtask

  task automatic t_cfg(input logic [3:0] ix, input logic [23:0] im);
    logic s0, n0;
    s0 = sign_o;
    n0 = nonzero_o;
    run(mk(cldec_pkg::OP_CFG_WR, 0, 0, 1'b1, im, 5'h00, 1'b0, 10'h000, ix));
    `CHK(wr1, 1'b1)
    `CHK(ee_addr_o, 10'(ix) * 10'h003)
    `CHK(ee_wdata_o, im)
    `CHK({sign_o, nonzero_o}, {s0, n0})
    exp_pc = exp_pc + 10'h003;
    `CHK(pc_o, exp_pc)
  endtask

  task automatic t_xnor(input int d, input int s, input logic ui, input logic [23:0] im);
    logic [23:0] e;
    e = ~(acc[d] ^ (ui ? im : acc[s]));
    run(mk(cldec_pkg::OP_XNOR, d, s, ui, im, 5'h00, 1'b0, 10'h000, 4'h0));
    `CHK(cyc, ui ? 6 : 3)
    `CHK(working_register_o[d], e)
    `CHK(working_register_o[s], (s == d) ? e : acc[s])
    `CHK({sign_o, nonzero_o}, {e[23], 1'(e != 24'h0)})
    exp_pc = exp_pc + (ui ? 10'h005 : 10'h002);
    `CHK(pc_o, exp_pc)
    acc[d] = e;
  endtask

  task automatic t_branch(input cldec_pkg::cldec_op_e op, input int r, input int c, input int a);
    logic [4:0] bs;
    logic [9:0] tg;
    logic [9:0] len;
    logic bitop, tk, ab;
    bs = c ? 5'h17 : 5'h00;
    ab = 1'(a);
    bitop = op == cldec_pkg::OP_BRANCH_BIT_CLEAR || op == cldec_pkg::OP_BRANCH_BIT_SET;
    // Relative offset 0xF0 steps back by sixteen
    tg = ab ? 10'h200 : 10'h0F0;
    case (op)
      cldec_pkg::OP_BRANCH_BIT_CLEAR: tk = !acc[r][bs];
      cldec_pkg::OP_BRANCH_BIT_SET: tk = acc[r][bs];
      cldec_pkg::OP_BRANCH_CARRY_CLEAR: tk = c == 0;
      cldec_pkg::OP_BRANCH_CARRY_SET: tk = c == 1;
      cldec_pkg::OP_BRANCH_RESULT_ZERO: tk = acc[r] == 24'h0;
      cldec_pkg::OP_BRANCH_RESULT_NONZERO: tk = acc[r] != 24'h0;
      cldec_pkg::OP_BRANCH_RESULT_NEGATIVE: tk = acc[r][23];
      cldec_pkg::OP_BRANCH_RESULT_POSITIVE: tk = !acc[r][23];
      default: tk = 1'b1;
    endcase
    len = (bitop || ab) ? 10'h003 : 10'h002;
    @(posedge ref_clk_i);
    carry_i <= 1'(c);
    run(mk(op, r, 0, 1'b0, 24'h0, bs, ab, tg, 4'h0));
    `CHK(cyc, (bitop || ab) ? 4 : 3)
    `CHK(branch_taken_o, tk)
    if (!tk)
      exp_pc = exp_pc + len;
    else if (bitop || ab)
      exp_pc = tg;
    else
      exp_pc = exp_pc + len + {{2{tg[7]}}, tg[7:0]};
    `CHK(pc_o, exp_pc)
  endtask

  initial begin
    reset_i = 1'b1;
    issue_valid_i = 1'b0;
    issue_instr_i = '0;
    carry_i = 1'b0;
    ram_addr_i = '0;
    ee_rdata_i = '0;
    n_errors = 0;
    compares = 0;
    for (int i = 0; i < 4; i++)
      acc[i] = 24'h0;
    t_reset();
    t_ee_read(0, 24'h5A5A5A, 10'h040);
    t_ee_read(1, 24'h800001, 10'h043);
    t_ee_read(2, 24'h000002, 10'h3FD);
    t_flag(3);
    t_cfg(4'h0, 24'hC3C3C3);
    t_flag(1);
    t_cfg(4'hF, 24'h00FF01);
    // Flag source covers zero, negative and positive; bit 0 and 23 ride on carry
    for (int r = 1; r < 4; r++)
      for (int c = 0; c < 2; c++)
        for (int o = 4; o <= 12; o++)
          for (int a = 0; a < 2; a++) begin
            t_flag(r);
            t_branch(cldec_pkg::cldec_op_e'(o), r, c, a);
          end
    for (int d = 0; d < 4; d++)
      t_xnor(d, (d + 1) % 4, 1'b0, 24'h0);
    t_xnor(1, 0, 1'b1, 24'hA5A5A5);
    t_xnor(3, 0, 1'b1, ~acc[3]);
    results();
  end
endmodule
